/* File: rtl/ipier_pkg.sv */
// constants and types for the pin-mode and interrupt-enable register bank
package ipier_pkg;
	localparam logic [4:0] PIN_MODE_ADDR = 5'h11;
	localparam logic [4:0] INT_EN_ADDR = 5'h12;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ_FLAGS = 2'h3;
	localparam logic [1:0] CMD_READ_STATUS = 2'h0;
	localparam logic [7:0] PIN_MODE_RESET = 8'h00;
	localparam logic [7:0] INT_EN_RESET = 8'h00;
	localparam int PIN_FIELD_W = 2;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_WAKE = 2'h1;
	localparam logic [1:0] MODE_LS = 2'h2;
	localparam logic [1:0] MODE_HS = 2'h3;
	localparam int INT_CAN_BIT = 7;
	localparam int INT_REQ_BIT = 6;
	localparam int INT_LIN_BIT = 4;
	localparam int INT_IO_BIT = 3;
	localparam int INT_SAFE_BIT = 2;
	localparam int INT_VMON_BIT = 0;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam int CLK_PERIOD_NS = 50;
	localparam int REQ_PULSE_NS = 100000;
	localparam int REQ_CYCLES_INT = (REQ_PULSE_NS / CLK_PERIOD_NS < 1) ? 1
		: REQ_PULSE_NS / CLK_PERIOD_NS;
	localparam logic [11:0] REQ_CYCLES = 12'(REQ_CYCLES_INT);

	typedef struct packed
	{
		logic can;
		logic lin;
		logic io;
		logic safe;
		logic vmon;
	} ipier_evt_t;

	typedef struct packed
	{
		logic [3:0] highSideDriver;
		logic [3:0] lowSideDriver;
		logic [3:0] wakeEn;
	} ipier_pins_t;

	typedef struct packed
	{
		logic [1:0] sclkSync;
		logic [1:0] csnSync;
		logic [1:0] mosiSync;
		logic sclkPrev;
		logic csnPrev;
		ipier_evt_t evtMeta;
		ipier_evt_t evtSync;
		logic [4:0] bitCnt;
		logic [15:0] rxSr;
		logic [7:0] txSr;
		logic miso;
		logic [7:0] pinMode;
		logic [7:0] intEn;
		ipier_evt_t flags;
		logic [11:0] reqCnt;
		logic intN;
		ipier_pins_t pins;
	} ipier_state_t;
endpackage

/* File: rtl/ipier_regs.sv */
// spi-written pin-mode and interrupt-enable registers with fault flags and interrupt line
// Functional notes
// R1 - pin-mode register written by 16-bit frame, address 10001
// R2 - interrupt-enable written by 16-bit frame, address 10010
// R3 - reset clears both registers to zero
// R4 - pin 3: off, wake, high-side
// R5 - pin 2: off, wake, high-side
// R6 - pin 1: off, wake, low-side, high-side
// R7 - pin 0: off, wake, low-side, high-side
// R8 - bit 7 enables can fault interrupt
// R9 - host request gives one single pulse
// R10 - host request needs bits 6 and 2
// R11 - bit 4 enables lin fault interrupt
// R12 - bit 3 enables i/o fault interrupt
// R13 - bit 2 enables safety event interrupt
// R14 - bit 0 enables supply monitor interrupt
// R15 - flags latch until read after recovery
// R16 - line asserts for enabled set flags only; the code also asserts it for the host request pulse
// R17 - bits 5 and 1 are ignored
module ipier_regs
#(
	parameter logic [3:0] LS_CAPABLE = 4'h3
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	output logic miso,
	input wire ipier_pkg::ipier_evt_t evtIn,
	output ipier_pkg::ipier_pins_t pins,
	output logic intN
);
	import ipier_pkg::*;

	ipier_state_t st;
	ipier_state_t nx;
	logic sclkRise;
	logic sclkFall;
	logic csnRise;
	logic frameDone;
	logic parityOk;
	logic wrPin;
	logic wrInt;
	logic clrFlags;
	logic reqFire;
	logic enabledHit;
	logic [7:0] respByte;
	logic [3:0] hsW;
	logic [3:0] lsW;
	logic [3:0] wakeW;

	assign sclkRise = st.sclkSync[1] & ~st.sclkPrev;
	assign sclkFall = ~st.sclkSync[1] & st.sclkPrev;
	assign csnRise = st.csnSync[1] & ~st.csnPrev;
	assign frameDone = csnRise && (st.bitCnt == FRAME_BITS);
	// odd parity over the whole frame
	assign parityOk = ^st.rxSr;
	assign wrPin = frameDone && parityOk && st.rxSr[15:14] == CMD_WRITE
		&& st.rxSr[13:9] == PIN_MODE_ADDR; // R1
	assign wrInt = frameDone && parityOk && st.rxSr[15:14] == CMD_WRITE
		&& st.rxSr[13:9] == INT_EN_ADDR; // R2
	assign clrFlags = frameDone && st.rxSr[15:14] == CMD_READ_FLAGS
		&& st.rxSr[13:9] == INT_EN_ADDR;
	assign reqFire = wrInt && st.rxSr[INT_REQ_BIT] && st.rxSr[INT_SAFE_BIT]; // R10

	// bits 5 and 1 take part in no interrupt
	assign enabledHit = (st.flags.can && st.intEn[INT_CAN_BIT]) // R8 R17
		|| (st.flags.lin && st.intEn[INT_LIN_BIT]) // R11
		|| (st.flags.io && st.intEn[INT_IO_BIT]) // R12
		|| (st.flags.safe && st.intEn[INT_SAFE_BIT]) // R13
		|| (st.flags.vmon && st.intEn[INT_VMON_BIT]); // R14

	// second byte answered on miso, chosen by the first byte
	always_comb
	begin
		respByte = 8'h00;
		if (st.rxSr[7:6] == CMD_READ_FLAGS)
		begin
			respByte[INT_CAN_BIT] = st.flags.can;
			respByte[INT_REQ_BIT] = st.reqCnt != 12'h000;
			respByte[INT_LIN_BIT] = st.flags.lin;
			respByte[INT_IO_BIT] = st.flags.io;
			respByte[INT_SAFE_BIT] = st.flags.safe;
			respByte[INT_VMON_BIT] = st.flags.vmon;
		end
		else if (st.rxSr[7:6] == CMD_READ_STATUS && st.rxSr[5:1] == PIN_MODE_ADDR)
		begin
			respByte = st.pinMode;
		end
		else if (st.rxSr[7:6] == CMD_READ_STATUS && st.rxSr[5:1] == INT_EN_ADDR)
		begin
			respByte = st.intEn;
		end
	end

	for (genvar i = 0; i < 4; i++)
	begin : g_pin
		wire logic [1:0] mode = st.pinMode[PIN_FIELD_W*i +: PIN_FIELD_W];
		assign wakeW[i] = mode == MODE_WAKE; // R4 R5 R6 R7
		assign lsW[i] = LS_CAPABLE[i] && mode == MODE_LS; // R6 R7
		assign hsW[i] = mode == MODE_HS || (!LS_CAPABLE[i] && mode == MODE_LS); // R4 R5
	end

	always_comb
	begin
		nx = st;
		nx.sclkSync = {st.sclkSync[0], sclk};
		nx.csnSync = {st.csnSync[0], csN};
		nx.mosiSync = {st.mosiSync[0], mosi};
		nx.sclkPrev = st.sclkSync[1];
		nx.csnPrev = st.csnSync[1];
		nx.evtMeta = evtIn;
		nx.evtSync = st.evtMeta;
		if (st.csnSync[1])
		begin
			nx.bitCnt = 5'h00;
			nx.miso = 1'b0;
		end
		else
		begin
			if (sclkRise && st.bitCnt < FRAME_BITS)
			begin
				nx.rxSr = {st.rxSr[14:0], st.mosiSync[1]};
				nx.bitCnt = st.bitCnt + 5'h01;
			end
			if (sclkFall)
			begin
				if (st.bitCnt == BYTE_BITS)
				begin
					nx.txSr = respByte;
				end
				else
				begin
					nx.txSr = {st.txSr[6:0], 1'b0};
				end
				nx.miso = nx.txSr[7];
			end
		end
		if (wrPin)
		begin
			nx.pinMode = st.rxSr[7:0];
		end
		if (wrInt)
		begin
			nx.intEn = st.rxSr[7:0];
		end
		// a live event wins over the read clear
		nx.flags = (clrFlags ? 5'h00 : st.flags) | st.evtSync; // R15
		if (reqFire)
		begin
			nx.reqCnt = REQ_CYCLES; // R9
		end
		else if (st.reqCnt != 12'h000)
		begin
			nx.reqCnt = st.reqCnt - 12'h001; // R9
		end
		nx.intN = ~(enabledHit || st.reqCnt != 12'h000); // R16
		nx.pins.highSideDriver = hsW;
		nx.pins.lowSideDriver = lsW;
		nx.pins.wakeEn = wakeW;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '0;
			// chip select idles high, so no false frame end after reset
			st.csnSync <= 2'h3;
			st.csnPrev <= 1'b1;
			st.pinMode <= PIN_MODE_RESET; // R3
			st.intEn <= INT_EN_RESET; // R3
			st.intN <= 1'b1;
		end
		else
		begin
			st <= nx;
		end
	end

	assign miso = st.miso;
	assign pins = st.pins;
	assign intN = st.intN;

	a_reset_clear: assert property (@(posedge mclk) // R3
		$rose(nrst) |-> st.pinMode == 8'h00 && st.intEn == 8'h00)
		else $error("registers not clear after reset");
	a_pin3_high: assert property (@(posedge mclk) disable iff (!nrst) // R4
		st.pinMode[7] && $stable(st.pinMode) |=> pins.highSideDriver[3] && !pins.wakeEn[3])
		else $error("pin 3 high-side not enabled");
	a_pin2_wake: assert property (@(posedge mclk) disable iff (!nrst) // R5
		st.pinMode[5:4] == MODE_WAKE && $stable(st.pinMode)
		|=> pins.wakeEn[2] && !pins.highSideDriver[2])
		else $error("pin 2 wake mode wrong");
	a_pin1_low: assert property (@(posedge mclk) disable iff (!nrst) // R6
		st.pinMode[3:2] == MODE_LS && $stable(st.pinMode)
		|=> pins.lowSideDriver[1] && !pins.highSideDriver[1])
		else $error("pin 1 low-side not enabled");
	a_pin0_off: assert property (@(posedge mclk) disable iff (!nrst) // R7
		st.pinMode[1:0] == MODE_OFF && $stable(st.pinMode)
		|=> !pins.lowSideDriver[0] && !pins.highSideDriver[0] && !pins.wakeEn[0])
		else $error("pin 0 not off");
	a_can_raise: assert property (@(posedge mclk) disable iff (!nrst) // R8
		st.flags.can && st.intEn[INT_CAN_BIT] |=> !intN)
		else $error("enabled can fault did not raise interrupt");
	a_mask_quiet: assert property (@(posedge mclk) disable iff (!nrst) // R16
		!enabledHit && st.reqCnt == 12'h000 |=> intN)
		else $error("interrupt without enabled flag");
	a_req_pulse: assert property (@(posedge mclk) disable iff (!nrst) // R9
		reqFire |=> st.reqCnt == REQ_CYCLES ##1 !intN
		##1 !intN && st.reqCnt == REQ_CYCLES - 12'h002)
		else $error("host request pulse missing");
	a_req_needs: assert property (@(posedge mclk) disable iff (!nrst) // R10
		wrInt && !(st.rxSr[INT_REQ_BIT] && st.rxSr[INT_SAFE_BIT]) && st.reqCnt == 12'h000
		|=> st.reqCnt == 12'h000)
		else $error("host request without both bits");
	a_req_single: assert property (@(posedge mclk) disable iff (!nrst) // R9
		st.reqCnt == 12'h001 && !reqFire |=> st.reqCnt == 12'h000)
		else $error("host request pulse not ended");
	a_flag_hold: assert property (@(posedge mclk) disable iff (!nrst) // R15
		st.flags.lin && !clrFlags |=> st.flags.lin)
		else $error("lin flag lost without read");
	a_write_int: assert property (@(posedge mclk) disable iff (!nrst) // R2
		wrInt |=> st.intEn == $past(st.rxSr[7:0]))
		else $error("interrupt-enable write not stored");
	a_write_pin: assert property (@(posedge mclk) disable iff (!nrst) // R1
		wrPin |=> st.pinMode == $past(st.rxSr[7:0]))
		else $error("pin-mode write not stored");
	a_reset_outs: assert property (@(posedge mclk) // R3
		$rose(nrst) |-> pins == 12'h000 && intN && !miso)
		else $error("outputs not idle after reset");
	a_pin3_wake: assert property (@(posedge mclk) disable iff (!nrst) // R4
		st.pinMode[7:6] == MODE_WAKE
		|=> pins.wakeEn[3] && !pins.highSideDriver[3] && !pins.lowSideDriver[3])
		else $error("pin 3 wake mode wrong");
	a_pin3_off: assert property (@(posedge mclk) disable iff (!nrst) // R4
		st.pinMode[7:6] == MODE_OFF
		|=> !pins.wakeEn[3] && !pins.highSideDriver[3] && !pins.lowSideDriver[3])
		else $error("pin 3 not off");
	a_pin2_high: assert property (@(posedge mclk) disable iff (!nrst) // R5
		st.pinMode[5]
		|=> pins.highSideDriver[2] && !pins.lowSideDriver[2] && !pins.wakeEn[2])
		else $error("pin 2 high-side not enabled");
	a_pin2_off: assert property (@(posedge mclk) disable iff (!nrst) // R5
		st.pinMode[5:4] == MODE_OFF
		|=> !pins.wakeEn[2] && !pins.highSideDriver[2] && !pins.lowSideDriver[2])
		else $error("pin 2 not off");
	a_pin1_high: assert property (@(posedge mclk) disable iff (!nrst) // R6
		st.pinMode[3:2] == MODE_HS
		|=> pins.highSideDriver[1] && !pins.lowSideDriver[1] && !pins.wakeEn[1])
		else $error("pin 1 high-side not enabled");
	a_pin1_wake: assert property (@(posedge mclk) disable iff (!nrst) // R6
		st.pinMode[3:2] == MODE_WAKE
		|=> pins.wakeEn[1] && !pins.highSideDriver[1] && !pins.lowSideDriver[1])
		else $error("pin 1 wake mode wrong");
	a_pin0_low: assert property (@(posedge mclk) disable iff (!nrst) // R7
		st.pinMode[1:0] == MODE_LS
		|=> pins.lowSideDriver[0] && !pins.highSideDriver[0] && !pins.wakeEn[0])
		else $error("pin 0 low-side not enabled");
	a_pin0_high: assert property (@(posedge mclk) disable iff (!nrst) // R7
		st.pinMode[1:0] == MODE_HS
		|=> pins.highSideDriver[0] && !pins.lowSideDriver[0] && !pins.wakeEn[0])
		else $error("pin 0 high-side not enabled");
	a_lin_raise: assert property (@(posedge mclk) disable iff (!nrst) // R11
		st.flags.lin && st.intEn[INT_LIN_BIT] |=> !intN)
		else $error("enabled lin fault did not raise interrupt");
	a_io_raise: assert property (@(posedge mclk) disable iff (!nrst) // R12
		st.flags.io && st.intEn[INT_IO_BIT] |=> !intN)
		else $error("enabled pin fault did not raise interrupt");
	a_safe_raise: assert property (@(posedge mclk) disable iff (!nrst) // R13
		st.flags.safe && st.intEn[INT_SAFE_BIT] |=> !intN)
		else $error("enabled safety event did not raise interrupt");
	a_vmon_raise: assert property (@(posedge mclk) disable iff (!nrst) // R14
		st.flags.vmon && st.intEn[INT_VMON_BIT] |=> !intN)
		else $error("enabled supply event did not raise interrupt");
	a_spare_ignored: assert property (@(posedge mclk) disable iff (!nrst) // R17
		({st.flags.can, st.flags.lin, st.flags.io, st.flags.safe, st.flags.vmon}
		& {st.intEn[INT_CAN_BIT], st.intEn[INT_LIN_BIT], st.intEn[INT_IO_BIT],
		st.intEn[INT_SAFE_BIT], st.intEn[INT_VMON_BIT]}) == 5'h00 && st.reqCnt == 12'h000
		|=> intN)
		else $error("interrupt from an ignored enable bit");
	a_req_step: assert property (@(posedge mclk) disable iff (!nrst) // R9
		st.reqCnt != 12'h000 && !reqFire |=> st.reqCnt == $past(st.reqCnt) - 12'h001)
		else $error("host request pulse not counting down");
	a_flag_set: assert property (@(posedge mclk) disable iff (!nrst) // R15
		st.evtSync != 5'h00 |=> (st.flags & $past(st.evtSync)) == $past(st.evtSync))
		else $error("event did not set its flag");
	a_flag_clear: assert property (@(posedge mclk) disable iff (!nrst) // R15
		clrFlags && st.evtSync == 5'h00 |=> st.flags == 5'h00)
		else $error("flags not cleared by read");
	a_flag_no_set: assert property (@(posedge mclk) disable iff (!nrst) // R15
		st.evtSync == 5'h00 |=> (st.flags & ~$past(st.flags)) == 5'h00)
		else $error("flag set without event");
	a_bad_parity: assert property (@(posedge mclk) disable iff (!nrst) // R1
		frameDone && !parityOk |=> $stable(st.pinMode) && $stable(st.intEn))
		else $error("write with bad parity stored");
	a_short_frame: assert property (@(posedge mclk) disable iff (!nrst) // R1
		csnRise && st.bitCnt != FRAME_BITS |=> $stable(st.pinMode) && $stable(st.intEn))
		else $error("frame of wrong length stored");
	a_other_addr: assert property (@(posedge mclk) disable iff (!nrst) // R2
		frameDone && st.rxSr[13:9] != PIN_MODE_ADDR && st.rxSr[13:9] != INT_EN_ADDR
		|=> $stable(st.pinMode) && $stable(st.intEn))
		else $error("write to other address stored");
	a_read_keeps: assert property (@(posedge mclk) disable iff (!nrst) // R2
		frameDone && st.rxSr[15:14] != CMD_WRITE
		|=> $stable(st.pinMode) && $stable(st.intEn))
		else $error("read frame changed a register");
endmodule // ipier_regs

/* File: verification/ipier_host.sv */
// spi master model standing in for the host controller
module ipier_host
(
	output logic sclk,
	output logic csN,
	output logic mosi,
	input wire logic mclk,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	// one frame of n bits, reply byte sampled during the second byte
	task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] r);
		r = 8'h00;
		@(negedge mclk) csN = 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			mosi = f[i];
			repeat (6) @(negedge mclk);
			if (i < 8)
				r[i] = miso;
			sclk = 1'b1;
			repeat (4) @(negedge mclk);
			sclk = 1'b0;
		end
		mosi = ~mosi;
		repeat (4) @(negedge mclk);
		csN = 1'b1;
		repeat (8) @(negedge mclk);
	endtask
	// odd parity over the frame, bad flips it
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic bad);
		logic [7:0] r;
		xfer({2'b01, a, bad ^ ~^{2'b01, a, d}, d}, 16, r);
	endtask
	// write frame cut one bit short
	task automatic cut(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer({2'b01, a, ~^{2'b01, a, d}, d}, 15, r);
	endtask
	task automatic rd(input logic [1:0] c, input logic [4:0] a, output logic [7:0] r);
		xfer({c, a, 1'b1, 8'h00}, 16, r);
	endtask
endmodule // ipier_host

/* File: verification/ipier_regs_test.sv */
// self-checking bench for the pin-mode and interrupt-enable registers
`define CHK(n, e, a) \
	begin \
		checks_done++; \
		if ((a) !== (e)) \
		begin \
			$display("BAD %s exp %h got %h", n, e, a); \
			err_total++; \
		end \
	end
module ipier_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ipier_pkg::*;
	logic mclk = 1'b0;
	logic nrst;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;
	logic intN;
	ipier_evt_t evtIn;
	ipier_pins_t pins;
	ipier_pins_t exp;
	logic [7:0] r;
	logic [7:0] m;
	logic [7:0] en [5] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h01};
	int err_total = 0;
	int checks_done = 0;
	always #25 mclk = ~mclk;
	ipier_host host (.sclk(sclk), .csN(csN), .mosi(mosi), .mclk(mclk), .miso(miso));
	ipier_regs dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .csN(csN), .mosi(mosi),
		.miso(miso), .evtIn(evtIn), .pins(pins), .intN(intN));
	task close_out();
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge mclk);
		err_total++;
		close_out();
	end
	initial
	begin
		nrst = 1'b0;
		evtIn = '0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("pins", 12'h000, pins)
		`CHK("intN", 1'b1, intN)
		host.rd(CMD_READ_STATUS, INT_EN_ADDR, r);
		`CHK("int rb", INT_EN_RESET, r)
		host.rd(CMD_READ_STATUS, PIN_MODE_ADDR, r);
		`CHK("mode rb", PIN_MODE_RESET, r)
		for (int v = 0; v < 4; v++)
		begin
			m = 8'(v * 8'h55);
			host.wr(PIN_MODE_ADDR, m, 1'b0);
			exp.highSideDriver = {{2{v[1]}}, {2{v == 3}}};
			exp.lowSideDriver = {2'b00, {2{v == 2}}};
			exp.wakeEn = {4{v == 1}};
			`CHK("pins", exp, pins)
			host.rd(CMD_READ_STATUS, PIN_MODE_ADDR, r);
			`CHK("mode rb", m, r)
		end
		host.wr(PIN_MODE_ADDR, 8'h00, 1'b1);
		host.cut(PIN_MODE_ADDR, 8'h00);
		host.wr(5'h13, 8'h00, 1'b0);
		`CHK("refused", exp, pins)
		host.wr(INT_EN_ADDR, 8'h02, 1'b0);
		evtIn = '1;
		repeat (8) @(negedge mclk);
		`CHK("masked", 1'b1, intN)
		host.rd(CMD_READ_FLAGS, INT_EN_ADDR, r);
		`CHK("flags held", 8'h9d, r)
		evtIn = '0;
		host.rd(CMD_READ_FLAGS, INT_EN_ADDR, r);
		`CHK("flags kept", 8'h9d, r)
		host.rd(CMD_READ_FLAGS, INT_EN_ADDR, r);
		`CHK("flags clr", 8'h00, r)
		for (int i = 0; i < 5; i++)
		begin
			evtIn = 5'(5'h10 >> i);
			repeat (8) @(negedge mclk);
			evtIn = '0;
			`CHK("off", 1'b1, intN)
			host.wr(INT_EN_ADDR, en[i], 1'b0);
			`CHK("on", 1'b0, intN)
			host.rd(CMD_READ_FLAGS, INT_EN_ADDR, r);
			`CHK("flag", en[i], r)
			`CHK("clr", 1'b1, intN)
			host.wr(INT_EN_ADDR, 8'h00, 1'b0);
		end
		host.wr(INT_EN_ADDR, 8'h40, 1'b0);
		`CHK("req alone", 1'b1, intN)
		host.wr(INT_EN_ADDR, 8'h44, 1'b0);
		`CHK("req on", 1'b0, intN)
		repeat (REQ_CYCLES_INT - 6) @(negedge mclk);
		`CHK("req hold", 1'b0, intN)
		repeat (2) @(negedge mclk);
		`CHK("req end", 1'b1, intN)
		nrst = 1'b0;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("pins", 12'h000, pins)
		host.rd(CMD_READ_STATUS, INT_EN_ADDR, r);
		`CHK("int rb", INT_EN_RESET, r)
		close_out();
	end
endmodule // ipier_regs_test
